// ==== rtl/gpc_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpc_debounce
   import gpc_pkg::*;
#(
   parameter int PERIOD_CYC = 256
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw pins and filtered result
   input wire logic [3:0] pinIn,
   output logic [3:0] filtOut
);
   localparam logic [FILT_CNT_W-1:0] LIM = FILT_CNT_W'(PERIOD_CYC - 1);

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] filt;
      logic [3:0][FILT_CNT_W-1:0] cnt;
   } gpc_deb_t;

   gpc_deb_t st_reg, st_next;

   // per bit: any bounce restarts the stability count
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = pinIn;
      st_next.s2 = st_reg.s1;
      for (int i = 0; i < 4; i++)
      begin
         if (st_reg.s2[i] == st_reg.filt[i])
            st_next.cnt[i] = '0;
         else if (st_reg.cnt[i] == LIM)
         begin
            st_next.filt[i] = st_reg.s2[i];
            st_next.cnt[i] = '0;
         end
         else
            st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
      end
   end

   // pins are pulled down, so filtered state starts low
   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign filtOut = st_reg.filt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_filter_full_period: assert property ($changed(st_reg.filt[0]) |->
      $past(st_reg.cnt[0]) == LIM)
      else $error("filtered bit changed before a full period");
   a_filter_follows: assert property ($changed(st_reg.filt[1]) |->
      st_reg.filt[1] == $past(st_reg.s2[1]))
      else $error("filtered bit took a level the pin did not hold");
   c_filter_change: cover property ($rose(st_reg.filt[0]));
endmodule
`default_nettype wire

// ==== rtl/gpc_pin_io.sv ====
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_io
   import gpc_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIV_DEF,
   parameter gpc_filt_t FILT_SEL = FILT_TYP,
   parameter bit BUZZ_ALT1K = 1'b0,
   parameter bit RES_ACTIVE_HIGH = 1'b0,
   parameter bit EDGE_RISING = 1'b1,
   parameter gpc_lcd_t LCD_METHOD = LCD_T4,
   parameter logic [NSEG-1:0] LCD_GP_MASK = 25'h0000000,
   parameter bit SEG_RESET_LIT = 1'b0,
   parameter bit GP_RESET_HIGH = 1'b0,
   parameter logic [3:0] OUT_RESET = 4'h0
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // dedicated inputs and their pull-downs
   input wire logic [3:0] switchInPort,
   input wire logic [3:0] dataInPort,
   output logic [3:0] pullDownEn,
   // bidirectional ports
   input wire logic [3:0] bidirAIn,
   output logic [3:0] bidirAOut,
   output logic [3:0] bidirAOe,
   input wire logic [3:0] bidirBIn,
   output logic [3:0] bidirBOut,
   output logic [3:0] bidirBOe,
   // dedicated outputs
   output logic [3:0] outLatchPort,
   output logic buzzerOut,
   output logic lampDriveOut,
   // init and interrupt pins, timer event from the core
   input wire logic chipInitPin,
   input wire logic edgeIrqPin,
   input wire logic tmrWrapPulse,
   // lcd
   output logic [NSEG-1:0] lcdDrivePin,
   output logic [NCOM-1:0] lcdBackplane,
   // interrupt
   output logic irq
);
   localparam int FILT_OSC = (FILT_SEL == FILT_SLOW) ? FILT_SLOW_OSC :
                             (FILT_SEL == FILT_FAST) ? FILT_FAST_OSC : FILT_TYP_OSC;
   localparam int FILT_CYC = FILT_OSC * OSC_DIV;
   localparam logic [12:0] OSC_LIM = 13'(OSC_DIV - 1);
   localparam bit THIRD = (LCD_METHOD == LCD_H3) || (LCD_METHOD == LCD_T3);
   localparam logic [9:0] ALT_LIM = THIRD ? 10'(ALT_THIRD_OSC - 1) : 10'(ALT_FULL_OSC - 1);
   localparam logic [2:0] COM_LINES = (LCD_METHOD == LCD_STATIC) ? 3'h1 :
                                      (LCD_METHOD == LCD_H2) ? 3'h2 :
                                      THIRD ? 3'h3 : 3'h4;
   localparam logic [NSEG-1:0] SEG_RST = (LCD_GP_MASK & {NSEG{GP_RESET_HIGH}}) |
                                         (~LCD_GP_MASK & {NSEG{SEG_RESET_LIT}});

   typedef struct packed {
      logic rS1;
      logic rS2;
      logic eS1;
      logic eS2;
      logic [3:0] aS1;
      logic [3:0] aS2;
      logic [3:0] bS1;
      logic [3:0] bS2;
      logic initAct;
      logic eOld;
      logic dirA;
      logic dirB;
      logic [3:0] outA;
      logic [3:0] outB;
      logic [3:0] outLatch;
      gpc_buzz_t buzzMode;
      logic lamp;
      logic pullEn;
      logic [NFLAGS-1:0] flags;
      logic [NFLAGS-1:0] mask;
      logic [NSEG-1:0] segData;
      logic [3:0] swOld;
      logic [3:0] dataOld;
      logic [12:0] oscCnt;
      logic [14:0] divCnt;
      logic [9:0] altCnt;
      logic altPol;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic buzz;
      logic [NSEG-1:0] lcdSeg;
      logic [NCOM-1:0] lcdCom;
   } gpc_state_t;

   // init synchronisers start at the idle level, else a released reset looks like an init pulse
   localparam gpc_state_t ST_RST = '{buzzMode: BZ_OFF, pullEn: 1'b1, outLatch: OUT_RESET,
                                     rS1: ~RES_ACTIVE_HIGH, rS2: ~RES_ACTIVE_HIGH,
                                     segData: SEG_RST, lcdSeg: SEG_RST, default: '0};

   gpc_state_t st_reg, st_next;
   logic [3:0] swFilt;
   logic [3:0] dataFilt;
   logic filtRst;

   // debouncers restart with the chip, so the init pin clears them too
   assign filtRst = rst | st_reg.initAct;

   gpc_debounce #(.PERIOD_CYC(FILT_CYC)) u_sw_filt (
      .clk(clk),
      .rst(filtRst),
      .pinIn(switchInPort),
      .filtOut(swFilt)
   );

   gpc_debounce #(.PERIOD_CYC(FILT_CYC)) u_data_filt (
      .clk(clk),
      .rst(filtRst),
      .pinIn(dataInPort),
      .filtOut(dataFilt)
   );

   logic access;
   logic done;
   logic wr;
   logic oscTick;
   logic edgeEv;
   logic [3:0] dataCh;
   logic [NFLAGS-1:0] ev;
   logic [NFLAGS-1:0] w1c;
   logic [31:0] rd;
   logic rdErr;
   logic [1:0] row;

   // whole next-state computation
   always_comb
   begin
      st_next = st_reg;
      // synchronisers
      st_next.rS1 = chipInitPin;
      st_next.rS2 = st_reg.rS1;
      st_next.eS1 = edgeIrqPin;
      st_next.eS2 = st_reg.eS1;
      st_next.aS1 = bidirAIn;
      st_next.aS2 = st_reg.aS1;
      st_next.bS1 = bidirBIn;
      st_next.bS2 = st_reg.bS1;
      st_next.initAct = (st_reg.rS2 == RES_ACTIVE_HIGH);
      st_next.eOld = st_reg.eS2;

      // oscillator tick and 15-stage divider
      oscTick = (st_reg.oscCnt == OSC_LIM);
      st_next.oscCnt = oscTick ? 13'h0000 : st_reg.oscCnt + 13'h0001;
      if (oscTick)
      begin
         st_next.divCnt = st_reg.divCnt + 15'h0001;
         if (st_reg.altCnt == ALT_LIM)
         begin
            st_next.altCnt = 10'h000;
            st_next.altPol = ~st_reg.altPol;
         end
         else
            st_next.altCnt = st_reg.altCnt + 10'h001;
      end

      // events
      edgeEv = EDGE_RISING ? (st_reg.eS2 & ~st_reg.eOld) : (~st_reg.eS2 & st_reg.eOld);
      dataCh = dataFilt ^ st_reg.dataOld;
      st_next.swOld = swFilt;
      st_next.dataOld = dataFilt;
      ev = '0;
      ev[FLG_DATA] = $onehot(dataCh) && ((dataFilt & ~dataCh) == 4'h0);
      ev[FLG_SW] = (swFilt != st_reg.swOld);
      ev[FLG_EDGE] = edgeEv;
      ev[FLG_TMR] = tmrWrapPulse;
      ev[FLG_DIV] = oscTick && (st_reg.divCnt == 15'h7fff);

      // apb: one wait state, write lands on the edge that sees pready
      access = psel & penable;
      done = access & st_reg.pready;
      rd = 32'h00000000;
      rdErr = 1'b0;
      case (paddr)
         REG_DIR: rd = {30'h00000000, st_reg.dirB, st_reg.dirA};
         REG_OUTP: rd = {28'h0000000, st_reg.outLatch};
         REG_PORTA: rd = {24'h000000, st_reg.outA, st_reg.aS2};
         REG_PORTB: rd = {24'h000000, st_reg.outB, st_reg.bS2};
         REG_SWIN: rd = {28'h0000000, swFilt};
         REG_DATAIN: rd = {28'h0000000, dataFilt};
         REG_MISC: rd = {28'h0000000, st_reg.pullEn, st_reg.lamp, 2'(st_reg.buzzMode)};
         REG_FLAGS: rd = {27'h0000000, st_reg.flags};
         REG_MASK: rd = {27'h0000000, st_reg.mask};
         REG_SEG: rd = {7'h00, st_reg.segData};
         default: rdErr = 1'b1;
      endcase
      st_next.pready = access & ~st_reg.pready;
      if (access & ~st_reg.pready)
      begin
         st_next.prdata = pwrite ? 32'h00000000 : rd;
         st_next.pslverr = rdErr;
      end
      wr = done & pwrite & ~rdErr;
      w1c = '0;
      if (wr)
      begin
         case (paddr)
            REG_DIR:
            begin
               st_next.dirA = pwdata[DIR_A];
               st_next.dirB = pwdata[DIR_B];
            end
            REG_OUTP: st_next.outLatch = pwdata[3:0];
            REG_PORTA: st_next.outA = pwdata[7:4];
            REG_PORTB: st_next.outB = pwdata[7:4];
            REG_MISC:
            begin
               st_next.buzzMode = (pwdata[1:0] == 2'h3) ? BZ_OFF : gpc_buzz_t'(pwdata[1:0]);
               st_next.lamp = pwdata[MISC_LAMP];
               st_next.pullEn = pwdata[MISC_PULL];
            end
            REG_FLAGS: w1c = pwdata[NFLAGS-1:0];
            REG_MASK: st_next.mask = pwdata[NFLAGS-1:0];
            REG_SEG: st_next.segData = pwdata[NSEG-1:0];
            default: w1c = '0;
         endcase
      end
      // an event in the clearing cycle survives
      st_next.flags = (st_reg.flags & ~w1c) | ev;

      // buzzer tone from divider stages
      case (st_next.buzzMode)
         BZ_TONE: st_next.buzz = st_next.divCnt[BUZZ_CARRIER_BIT];
         BZ_MOD: st_next.buzz = st_next.divCnt[BUZZ_CARRIER_BIT] &
                                (BUZZ_ALT1K ? st_next.divCnt[BUZZ_ENV1K_BIT] :
                                              st_next.divCnt[BUZZ_ENV2K_BIT]);
         default: st_next.buzz = 1'b0;
      endcase

      // backplane scan; bias levels are analog and not modelled here
      case (LCD_METHOD)
         LCD_STATIC: row = 2'h0;
         LCD_H2: row = {1'b0, st_next.altCnt[9]};
         default: row = st_next.altCnt[9:8];
      endcase
      for (int i = 0; i < NCOM; i++)
      begin
         st_next.lcdCom[i] = (3'(i) < COM_LINES) ? ((2'(i) == row) ^ st_next.altPol) : 1'b0;
      end
      // lit segment sits opposite the selected backplane; general pins are plain levels
      for (int k = 0; k < NSEG; k++)
      begin
         st_next.lcdSeg[k] = LCD_GP_MASK[k] ? st_next.segData[k] :
                             (st_next.segData[k] ~^ st_next.altPol);
      end

      // init pin puts the port back to its reset picture, synchronisers excepted
      if (st_reg.initAct)
      begin
         st_next = ST_RST;
         st_next.rS1 = chipInitPin;
         st_next.rS2 = st_reg.rS1;
         st_next.eS1 = edgeIrqPin;
         st_next.eS2 = st_reg.eS1;
         st_next.aS1 = bidirAIn;
         st_next.aS2 = st_reg.aS1;
         st_next.bS1 = bidirBIn;
         st_next.bS2 = st_reg.bS1;
         st_next.initAct = (st_reg.rS2 == RES_ACTIVE_HIGH);
         st_next.eOld = st_reg.eS2;
      end
      st_next.irq = |(st_next.flags & st_next.mask);
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= ST_RST;
      else
         st_reg <= st_next;
   end

   // outputs straight from the state register
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign pullDownEn = {4{st_reg.pullEn}};
   assign bidirAOut = st_reg.outA;
   assign bidirAOe = {4{st_reg.dirA}};
   assign bidirBOut = st_reg.outB;
   assign bidirBOe = {4{st_reg.dirB}};
   assign outLatchPort = st_reg.outLatch;
   assign buzzerOut = st_reg.buzz;
   assign lampDriveOut = st_reg.lamp;
   assign lcdDrivePin = st_reg.lcdSeg;
   assign lcdBackplane = st_reg.lcdCom;
   assign irq = st_reg.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pull_on_init: assert property (st_reg.initAct |=> pullDownEn == 4'hf)
      else $error("pull-downs off after init");
   a_dir_input_init: assert property (st_reg.initAct |=>
      (bidirAOe == 4'h0) && (bidirBOe == 4'h0))
      else $error("bidirectional port not input after init");
   a_quiet_outs_init: assert property (st_reg.initAct |=>
      !lampDriveOut && !buzzerOut)
      else $error("lamp or buzzer not low after init");
   a_init_polarity: assert property ((st_reg.rS2 == RES_ACTIVE_HIGH) |=> st_reg.initAct)
      else $error("init pin level not recognised");
   a_out_latch_hold: assert property (!(wr && paddr == REG_OUTP) && !st_reg.initAct |=>
      $stable(outLatchPort))
      else $error("output latch moved without a write");
   a_edge_flag_set: assert property (edgeEv |=> st_reg.flags[FLG_EDGE] ##1
      (st_reg.flags[FLG_EDGE] || $past(wr && paddr == REG_FLAGS)))
      else $error("edge event lost");
   a_gp_pins_still: assert property (!(wr && paddr == REG_SEG) && !st_reg.initAct |=>
      $stable(lcdDrivePin & LCD_GP_MASK))
      else $error("general lcd pin moved without a write");
   a_com_unused_low: assert property ((lcdBackplane >> COM_LINES) == 4'h0)
      else $error("unused backplane line driven");
   a_data_flag_cond: assert property ($rose(st_reg.flags[FLG_DATA]) |->
      $countones($past(dataFilt)) <= 1)
      else $error("data flag set with other inputs high");
   a_sw_irq_level: assert property ($rose(st_reg.flags[FLG_SW]) && st_reg.mask[FLG_SW] |-> irq)
      else $error("unmasked switch flag without interrupt");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held over two cycles");

   c_reg_write: cover property (wr ##1 access);
   c_edge_irq: cover property (edgeEv ##1 irq);
   c_data_flag: cover property ($rose(st_reg.flags[FLG_DATA]));
   c_init_pulse: cover property ($rose(st_reg.initAct) ##[1:100] $fell(st_reg.initAct));
endmodule
`default_nettype wire

// ==== rtl/gpc_pkg.sv ====
package gpc_pkg;
   // clock and oscillator timing
   localparam int CLK_HZ = 200_000_000;
   localparam int OSC_HZ = 32768;
   localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ; // clk cycles per oscillator tick
   localparam int RES_MIN_US = 500;
   localparam int RES_MIN_CYC = (RES_MIN_US * (CLK_HZ / 1_000_000));

   // chattering filter periods, ms and oscillator ticks
   localparam int FILT_SLOW_MS = 32;
   localparam int FILT_TYP_MS = 8;
   localparam int FILT_FAST_MS = 2;
   localparam int FILT_SLOW_OSC = 1024;
   localparam int FILT_TYP_OSC = 256;
   localparam int FILT_FAST_OSC = 64;
   localparam int FILT_CNT_W = 24;

   // buzzer tones as divider stages: 4 kHz carrier, 2 kHz or 1 kHz envelope
   localparam int BUZZ_CARRIER_BIT = 2;
   localparam int BUZZ_ENV2K_BIT = 3;
   localparam int BUZZ_ENV1K_BIT = 4;

   // lcd alternation: 32 Hz from 1024 ticks, 42.7 Hz from 768 ticks
   localparam int ALT_FULL_OSC = 1024;
   localparam int ALT_THIRD_OSC = 768;
   localparam int NSEG = 25;
   localparam int NCOM = 4;

   // register byte offsets
   localparam logic [7:0] REG_DIR = 8'h00;
   localparam logic [7:0] REG_OUTP = 8'h04;
   localparam logic [7:0] REG_PORTA = 8'h08;
   localparam logic [7:0] REG_PORTB = 8'h0c;
   localparam logic [7:0] REG_SWIN = 8'h10;
   localparam logic [7:0] REG_DATAIN = 8'h14;
   localparam logic [7:0] REG_MISC = 8'h18;
   localparam logic [7:0] REG_FLAGS = 8'h1c;
   localparam logic [7:0] REG_MASK = 8'h20;
   localparam logic [7:0] REG_SEG = 8'h24;

   // field positions
   localparam int DIR_A = 0;
   localparam int DIR_B = 1;
   localparam int MISC_LAMP = 2;
   localparam int MISC_PULL = 3;
   localparam int FLG_DATA = 0;
   localparam int FLG_SW = 1;
   localparam int FLG_EDGE = 2;
   localparam int FLG_TMR = 3;
   localparam int FLG_DIV = 4;
   localparam int NFLAGS = 5;

   typedef enum logic [1:0] {BZ_OFF, BZ_TONE, BZ_MOD} gpc_buzz_t;
   typedef enum logic [2:0] {LCD_STATIC, LCD_H2, LCD_H3, LCD_H4, LCD_T3, LCD_T4} gpc_lcd_t;
   typedef enum logic [1:0] {FILT_SLOW, FILT_TYP, FILT_FAST} gpc_filt_t;
endpackage

// ==== test/gpc_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpc_far_side
   import gpc_pkg::*;
(
   // pattern clock
   input wire logic clk,
   // buttons and pull-downs
   input wire logic [3:0] swPress,
   input wire logic [3:0] dataPress,
   input wire logic [3:0] pullDownEn,
   output logic [3:0] switchInPort,
   output logic [3:0] dataInPort,
   // two-way ports
   input wire logic [3:0] extAEn,
   input wire logic [3:0] extBEn,
   input wire logic [3:0] extVal,
   input wire logic [3:0] bidirAOut,
   input wire logic [3:0] bidirAOe,
   input wire logic [3:0] bidirBOut,
   input wire logic [3:0] bidirBOe,
   output logic [3:0] bidirAIn,
   output logic [3:0] bidirBIn
);
   logic flip = 1'b0;
   // floating lines wander so no lucky settle to 0
   always @(posedge clk) flip <= ~flip;
   // released button reads the pull-down, or floats when it is off
   assign switchInPort = swPress | (~pullDownEn & {4{flip}});
   assign dataInPort = dataPress | (~pullDownEn & {4{flip}});
   // wire level from both parties' enables
   assign bidirAIn = (bidirAOe & bidirAOut) | (~bidirAOe & extAEn & extVal) |
      (~bidirAOe & ~extAEn & {4{flip}});
   assign bidirBIn = (bidirBOe & bidirBOut) | (~bidirBOe & extBEn & extVal) |
      (~bidirBOe & ~extBEn & {4{flip}});
endmodule
`default_nettype wire

// ==== test/tb_mcu_pin_io_behaviour.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_mcu_pin_io_behaviour
   import gpc_pkg::*;
();
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} gpc_row_t;
   localparam logic [NSEG-1:0] GPM = 25'h00000f0;
   localparam int TB_OSC_DIV = 2;
   // oscillator ticks are TB_OSC_DIV clocks here, so the init hold shrinks in proportion
   localparam int INIT_HOLD = ((RES_MIN_US * OSC_HZ) / 1_000_000 + 1) * TB_OSC_DIV;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic pready, pslverr, rdErr, buzzerOut, lampDriveOut, irq;
   logic [3:0] swIn, dataIn, pullDownEn, bidirAIn, bidirAOut, bidirAOe, outLatchPort;
   logic [3:0] bidirBIn, bidirBOut, bidirBOe;
   logic [3:0] swPress = 4'h0, dataPress = 4'h0, extAEn = 4'h0, extVal = 4'h0, hi, lo;
   logic [3:0] extBEn = 4'h0;
   logic edgeIrqPin = 1'b0, tmrWrapPulse = 1'b0, chipInitPin = 1'b1;
   logic [NSEG-1:0] lcdDrivePin, segHi;
   logic [NCOM-1:0] lcdBackplane;
   int failCount = 0, testsRun = 0, n1, n2;
   gpc_row_t rows [14] = '{
      '{1'b0, REG_DIR, 32'h0, 32'h0, 1'b0}, '{1'b0, REG_MISC, 32'h0, 32'h8, 1'b0},
      '{1'b0, REG_MASK, 32'h0, 32'h0, 1'b0}, '{1'b0, REG_FLAGS, 32'h0, 32'h0, 1'b0},
      '{1'b1, REG_DIR, 32'h3, 32'h0, 1'b0}, '{1'b1, REG_PORTA, 32'ha0, 32'h0, 1'b0},
      '{1'b1, REG_PORTB, 32'h50, 32'h0, 1'b0}, '{1'b0, REG_PORTA, 32'h0, 32'haa, 1'b0},
      '{1'b0, REG_PORTB, 32'h0, 32'h55, 1'b0}, '{1'b1, REG_OUTP, 32'h9, 32'h0, 1'b0},
      '{1'b0, REG_OUTP, 32'h0, 32'h9, 1'b0}, '{1'b0, 8'h28, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h3c, 32'hffff, 32'h0, 1'b1}, '{1'b1, REG_DIR, 32'h0, 32'h0, 1'b0}};

   // short oscillator divider and fast filter keep the run brief
   gpc_pin_io #(.OSC_DIV(TB_OSC_DIV), .FILT_SEL(FILT_FAST), .EDGE_RISING(1'b1), .LCD_GP_MASK(GPM),
      .GP_RESET_HIGH(1'b1), .SEG_RESET_LIT(1'b0)) DUT (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .switchInPort(swIn), .dataInPort(dataIn), .pullDownEn(pullDownEn),
      .bidirAIn(bidirAIn), .bidirAOut(bidirAOut), .bidirAOe(bidirAOe),
      .bidirBIn(bidirBIn), .bidirBOut(bidirBOut), .bidirBOe(bidirBOe),
      .outLatchPort(outLatchPort), .buzzerOut(buzzerOut), .lampDriveOut(lampDriveOut),
      .chipInitPin(chipInitPin), .edgeIrqPin(edgeIrqPin), .tmrWrapPulse(tmrWrapPulse),
      .lcdDrivePin(lcdDrivePin), .lcdBackplane(lcdBackplane), .irq(irq));

   gpc_far_side far (
      .clk(clk), .swPress(swPress), .dataPress(dataPress), .pullDownEn(pullDownEn),
      .switchInPort(swIn), .dataInPort(dataIn), .extAEn(extAEn), .extBEn(extBEn),
      .extVal(extVal), .bidirAOut(bidirAOut), .bidirAOe(bidirAOe), .bidirBOut(bidirBOut),
      .bidirBOe(bidirBOe), .bidirAIn(bidirAIn), .bidirBIn(bidirBIn));

   // 200 MHz clock
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // pready is read as the edge arrives, before the slave updates it
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      `CHK("pready", 1'b1, pready);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // rising edges of the buzzer over 256 cycles
   task automatic cnt(output int n);
      logic p;
      n = 0;
      p = buzzerOut;
      repeat (256)
      begin
         @(negedge clk);
         if (buzzerOut && !p) n++;
         p = buzzerOut;
      end
   endtask

   task automatic finish_test();
      if (failCount == 0 && testsRun > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard, well beyond the expected run
   initial
   begin
      cyc(20000);
      failCount++;
      finish_test();
   end

   initial
   begin
      cyc(3);
      @(negedge clk);
      `CHK("pulldown", 4'hf, pullDownEn);
      `CHK("oe", 8'h00, {bidirAOe, bidirBOe});
      `CHK("buzlamp", 2'b00, {buzzerOut, lampDriveOut});
      `CHK("seg", GPM, lcdDrivePin);
      `CHK("bp", 4'h0, lcdBackplane);
      cyc(3);
      rst <= 1'b0;
      for (int i = 0; i < 14; i++)
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         `CHK("rdata", rows[i].q, rdData);
         `CHK("slverr", rows[i].e, rdErr);
      end
      extAEn <= 4'hf;
      extBEn <= 4'hf;
      extVal <= 4'h3;
      @(negedge clk);
      `CHK("outp", 4'h9, outLatchPort);
      `CHK("oeoff", 8'h00, {bidirAOe, bidirBOe});
      cyc(4);
      apb(1'b0, REG_PORTA, 32'h0);
      `CHK("porta", 32'ha3, rdData);
      apb(1'b0, REG_PORTB, 32'h0);
      `CHK("portb", 32'h53, rdData);
      extAEn <= 4'h0;
      extBEn <= 4'h0;
      // a glitch shorter than the filter period must vanish
      swPress <= 4'h1;
      cyc(60);
      swPress <= 4'h0;
      cyc(200);
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("glitch", 32'h0, rdData);
      apb(1'b1, REG_MASK, 32'h1f);
      swPress <= 4'h1;
      cyc(100);
      apb(1'b0, REG_SWIN, 32'h0);
      `CHK("swearly", 32'h0, rdData);
      cyc(40);
      apb(1'b0, REG_SWIN, 32'h0);
      `CHK("swin", 32'h1, rdData);
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("swflag", 32'h2, rdData);
      `CHK("irq", 1'b1, irq);
      apb(1'b1, REG_FLAGS, 32'h2);
      dataPress <= 4'h4;
      @(negedge clk);
      `CHK("irqclr", 1'b0, irq);
      cyc(160);
      apb(1'b0, REG_DATAIN, 32'h0);
      `CHK("datain", 32'h4, rdData);
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("dflag", 32'h1, rdData);
      apb(1'b1, REG_FLAGS, 32'h1);
      dataPress <= 4'h6;
      cyc(160);
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("dnoflag", 32'h0, rdData);
      edgeIrqPin <= 1'b1;
      cyc(5);
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("rise", 32'h4, rdData);
      apb(1'b1, REG_FLAGS, 32'h4);
      edgeIrqPin <= 1'b0;
      cyc(5);
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("fall", 32'h0, rdData);
      apb(1'b1, REG_MASK, 32'h0);
      tmrWrapPulse <= 1'b1;
      cyc(1);
      tmrWrapPulse <= 1'b0;
      apb(1'b0, REG_FLAGS, 32'h0);
      `CHK("tmr", 32'h8, rdData);
      `CHK("masked", 1'b0, irq);
      apb(1'b1, REG_MISC, 32'h4);
      @(negedge clk);
      `CHK("lamp", 2'b10, {lampDriveOut, pullDownEn[0]});
      cnt(n1);
      `CHK("quiet", 0, n1);
      apb(1'b1, REG_MISC, 32'h9);
      cnt(n1);
      apb(1'b1, REG_MISC, 32'ha);
      cnt(n2);
      // carrier: divider stage 2 of 2-cycle ticks gives 16 edges in 256
      `CHK("tone", 1'b1, (n1 >= 15 && n1 <= 17));
      `CHK("mod", 1'b1, (n2 > 0 && n2 < n1));
      apb(1'b1, REG_SEG, 32'h1ffffff);
      hi = 4'h0;
      lo = 4'h0;
      segHi = '0;
      repeat (5000)
      begin
         @(negedge clk);
         hi = hi | lcdBackplane;
         lo = lo | ~lcdBackplane;
         segHi = segHi | lcdDrivePin;
      end
      `CHK("bplines", 8'hff, {hi, lo});
      `CHK("seglit", {NSEG{1'b1}}, segHi);
      `CHK("gpout", GPM, lcdDrivePin & GPM);
      apb(1'b1, REG_SEG, 32'h0);
      @(negedge clk);
      `CHK("gpzero", 25'h0, lcdDrivePin & GPM);
      apb(1'b1, REG_MISC, 32'h4);
      rst <= 1'b1;
      cyc(6);
      @(negedge clk);
      `CHK("rerst", 5'h0f, {lampDriveOut, pullDownEn});
      @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, REG_MISC, 32'h0);
      `CHK("misc", 32'h8, rdData);
      // init pin, active low here, must bring back the reset picture
      apb(1'b1, REG_DIR, 32'h3);
      apb(1'b1, REG_MISC, 32'h4);
      chipInitPin <= 1'b0;
      cyc(INIT_HOLD);
      @(negedge clk);
      `CHK("init", 13'h0f00, {lampDriveOut, pullDownEn, bidirAOe, bidirBOe});
      @(posedge clk);
      chipInitPin <= 1'b1;
      // the design leaves init three edges after the pin goes idle
      cyc(4);
      apb(1'b0, REG_DIR, 32'h0);
      `CHK("initdir", 32'h0, rdData);
      finish_test();
   end
endmodule
`default_nettype wire
